// ==== core/exposure_trigger_control.sv ====
/*
 * Camera-side exposure controller: start-trigger selection, edge detection,
 * trigger delay timer, timed and trigger-width exposure, free-run generation,
 * global-shutter exposure and line-by-line readout sequencing.
 * Assumes trigger inputs and settings are synchronous to mclk; settings are
 * plain inputs held steady by the surrounding logic.
 */
// The implementer's own choices: the APB interface to the registers and the register addresses.
// Notes on behaviour
// - Hardware line edges start exposure when selected
// - Edge select chooses rising or falling start
// - Waiting state starts on every selected edge
// - Started exposure leaves waiting, ignores further triggers
// - Returns to waiting automatically when ready again
// - Timer source inserts delay after hardware trigger
// - Delay counted in microseconds from line
// - Timed mode exposes for programmed time
// - Timed mode drops triggers during exposure
// - Width mode rising: expose until falling edge
// - Exposure time held within 12 to 60000000 us
// - Width mode has no upper exposure limit
// - Programmed time except width mode uses level
// - New exposure may overlap previous readout
// - Partner must not start during active exposure
// - Partner must not end before readout finishes
// - All lines start and stop exposing together
// - Readout starts right after exposure, line by line
// - Exposure-active output follows exposure
// - Trigger off: free run at capped rate
// - Source select picks among five sources
// - Timer source width mode uses timer duration
// - Software triggers ignored when not ready
`timescale 1ns/1ps
`default_nettype none
module exposure_trigger_control
    import exposure_pkg::*;
#(
    parameter int LINES = 16, // Sensor lines per frame
    parameter int LINE_CYCLES = 64 // Clocks to read one line
) (
    input wire logic mclk, // Camera clock
    input wire logic reset_n, // Synchronous reset, active low
    exposure_link_if.device link, // Trigger lines and status to partner
    input wire logic trigger_enable, // Triggered mode; low means free run
    input wire logic [2:0] source_sel, // Start trigger source
    input wire logic edge_rising, // High: rising edge starts
    input wire logic width_mode, // High: trigger-width exposure
    input wire logic [TIME_W-1:0] exposure_time_us, // Programmed exposure
    input wire logic [TIME_W-1:0] delay_us, // Trigger delay
    input wire logic [TIME_W-1:0] timer_duration_us, // Timer output length
    input wire logic [TIME_W-1:0] frame_period_us, // Free-run period
    input wire logic software_trigger, // One-cycle software start command
    input wire logic software_level_output, // Software-driven trigger level
    output logic waiting_r, // Waiting for exposure start
    output logic delay_timer_output_r, // Timer active level
    output logic frame_start_r, // Pulse when exposure begins
    output logic line_strobe_r, // Pulse as each line is read
    output logic [15:0] line_index_r // Line being read
);
    typedef enum logic [1:0] {ST_WAIT, ST_DELAY, ST_EXPOSE} exp_state_e;

    exp_state_e state_r;
    logic [7:0] presc_r;
    logic [TIME_W-1:0] cnt_r;
    logic [TIME_W-1:0] period_cnt_r;
    logic due_r;
    logic trig_prev_r;
    logic exposing_r;
    logic readout_r;
    logic [15:0] line_cyc_r;
    logic us_tick;
    logic trig_cur;
    logic act_edge;
    logic end_edge;
    logic start_now;
    logic end_now;
    logic level_src;
    logic delay_go;
    trig_src_e src;

    // Keeps a programmed time inside the legal exposure range
    function automatic logic [TIME_W-1:0] clamp_exp(input logic [TIME_W-1:0] t);
        if (t < EXP_MIN_US) begin
            return EXP_MIN_US;
        end else if (t > EXP_MAX_US) begin
            return EXP_MAX_US;
        end
        return t;
    endfunction

    assign src = trig_src_e'(source_sel);
    assign us_tick = (presc_r == US_LAST);

    // Raw level of the selected source; timer runs from the hardware line
    always_comb begin
        case (src)
            SRC_LEVEL: trig_cur = software_level_output;
            SRC_LINK: trig_cur = link.link_trigger_input;
            SRC_TIMER: trig_cur = link.hardware_trigger_input;
            SRC_LINE: trig_cur = link.hardware_trigger_input;
            default: trig_cur = 1'b0;
        endcase
    end

    // Edge polarity chosen by the edge-select setting
    assign act_edge = edge_rising ? (trig_cur & ~trig_prev_r)
                                  : (~trig_cur & trig_prev_r);
    assign end_edge = edge_rising ? (~trig_cur & trig_prev_r)
                                  : (trig_cur & ~trig_prev_r);
    assign level_src = (src == SRC_LINE) || (src == SRC_LINK) || (src == SRC_LEVEL);
    assign delay_go = trigger_enable && (src == SRC_TIMER) && act_edge;

    // Start decision, taken in the waiting state or when the delay state's count expires
    always_comb begin
        start_now = 1'b0;
        if (state_r == ST_WAIT) begin
            if (!trigger_enable) begin
                start_now = due_r;
            end else begin
                case (src)
                    SRC_SOFTWARE: start_now = software_trigger;
                    SRC_TIMER: start_now = 1'b0;
                    default: start_now = act_edge;
                endcase
            end
        end else if (state_r == ST_DELAY) begin
            start_now = us_tick && (cnt_r >= delay_us);
        end
    end

    // End decision; never ends before the previous readout has drained
    always_comb begin
        end_now = 1'b0;
        if (state_r == ST_EXPOSE && !readout_r) begin
            if (trigger_enable && width_mode && level_src) begin
                end_now = end_edge;
            end else if (trigger_enable && width_mode && src == SRC_TIMER) begin
                end_now = us_tick && (cnt_r + 26'd1 >= timer_duration_us);
            end else begin
                end_now = us_tick
                    && (cnt_r + 26'd1 >= clamp_exp(exposure_time_us));
            end
        end
    end

    // Free-running microsecond prescaler shared by all timers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            presc_r <= 8'h00;
        end else if (us_tick) begin
            presc_r <= 8'h00;
        end else begin
            presc_r <= presc_r + 8'h01;
        end
    end

    // Previous level of the selected source, for edge detection
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            trig_prev_r <= 1'b0;
        end else begin
            trig_prev_r <= trig_cur;
        end
    end

    // Acquisition state; triggers outside the waiting state fall on the floor
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_r <= ST_WAIT;
        end else begin
            case (state_r)
                ST_WAIT: begin
                    if (delay_go) begin
                        state_r <= ST_DELAY;
                    end else if (start_now) begin
                        state_r <= ST_EXPOSE;
                    end
                end
                ST_DELAY: begin
                    if (start_now) begin
                        state_r <= ST_EXPOSE;
                    end
                end
                ST_EXPOSE: begin
                    if (end_now) begin
                        state_r <= ST_WAIT;
                    end
                end
                default: state_r <= ST_WAIT;
            endcase
        end
    end

    // Microsecond count for delay and exposure, restarted at each phase
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cnt_r <= '0;
        end else if (start_now || state_r == ST_WAIT) begin
            cnt_r <= '0;
        end else if (us_tick && cnt_r != EXP_MAX_US) begin
            cnt_r <= cnt_r + 26'd1;
        end
    end

    // Free-run period; a start owed while busy fires once ready (rate cap)
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            period_cnt_r <= '0;
            due_r <= 1'b0;
        end else if (!trigger_enable && start_now) begin
            period_cnt_r <= '0;
            due_r <= 1'b0;
        end else if (!trigger_enable && us_tick) begin
            if (period_cnt_r + 26'd1 >= frame_period_us) begin
                due_r <= 1'b1;
            end else begin
                period_cnt_r <= period_cnt_r + 26'd1;
            end
        end else if (trigger_enable) begin
            period_cnt_r <= '0;
            due_r <= 1'b0;
        end
    end

    // Global shutter: one exposure level for every line
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            exposing_r <= 1'b0;
            frame_start_r <= 1'b0;
            waiting_r <= 1'b1;
            delay_timer_output_r <= 1'b0;
        end else begin
            frame_start_r <= start_now && state_r != ST_EXPOSE;
            if (start_now) begin
                exposing_r <= 1'b1;
            end else if (end_now) begin
                exposing_r <= 1'b0;
            end
            waiting_r <= (state_r == ST_WAIT) ? ~(start_now || delay_go) : end_now;
            if (start_now && src == SRC_TIMER && trigger_enable) begin
                delay_timer_output_r <= 1'b1;
            end else if (end_now) begin
                delay_timer_output_r <= 1'b0;
            end
        end
    end

    // Readout follows the end of exposure; a new exposure may run alongside
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            readout_r <= 1'b0;
            line_cyc_r <= 16'h0000;
            line_index_r <= 16'h0000;
            line_strobe_r <= 1'b0;
        end else begin
            line_strobe_r <= 1'b0;
            if (end_now) begin
                readout_r <= 1'b1;
                line_cyc_r <= 16'h0000;
                line_index_r <= 16'h0000;
                line_strobe_r <= 1'b1;
            end else if (readout_r) begin
                if (line_cyc_r == 16'(LINE_CYCLES - 1)) begin
                    line_cyc_r <= 16'h0000;
                    if (line_index_r == 16'(LINES - 1)) begin
                        readout_r <= 1'b0;
                    end else begin
                        line_index_r <= line_index_r + 16'h0001;
                        line_strobe_r <= 1'b1;
                    end
                end else begin
                    line_cyc_r <= line_cyc_r + 16'h0001;
                end
            end
        end
    end

    assign link.exposure_active = exposing_r;
    assign link.readout_busy = readout_r;
endmodule // exposure_trigger_control
`default_nettype wire

// ==== core/exposure_pkg.sv ====
/*
 * Shared constants for the exposure trigger controller and its trigger-source
 * partner: time base, exposure limits, source and mode codes, register map.
 * Assumes one 250 MHz clock shared by both ends.
 */
package exposure_pkg;
    // Time base
    localparam int CLK_PERIOD_PS = 4000;
    localparam int US_PS = 1000000;
    localparam int US_CYCLES = US_PS / CLK_PERIOD_PS;
    localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1);

    // Exposure time limits in microseconds
    localparam int TIME_W = 26;
    localparam logic [TIME_W-1:0] EXP_MIN_US = 26'd12;
    localparam logic [TIME_W-1:0] EXP_MAX_US = 26'd60000000;

    // Start trigger sources
    typedef enum logic [2:0] {
        SRC_SOFTWARE,
        SRC_LEVEL,
        SRC_LINK,
        SRC_TIMER,
        SRC_LINE
    } trig_src_e;

    // Partner register map (byte offsets) and fields
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WIDTH = 8'h04;
    localparam logic [7:0] REG_GO = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam int CTRL_USE_LINK = 0;
    localparam int CTRL_ACTIVE_HIGH = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    localparam logic [31:0] WIDTH_RESET = 32'h0000_0100;
endpackage

// ==== core/exposure_link_if.sv ====
/*
 * Wires between the trigger source and the camera exposure controller.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface exposure_link_if;
    logic hardware_trigger_input; // Electrical trigger line
    logic link_trigger_input; // Trigger carried over the link
    logic exposure_active; // High while the sensor exposes
    logic readout_busy; // High while a frame is read out

    modport device (
        input hardware_trigger_input, link_trigger_input,
        output exposure_active, readout_busy
    );
    modport host (
        output hardware_trigger_input, link_trigger_input,
        input exposure_active, readout_busy
    );
endinterface
`default_nettype wire

// ==== core/trigger_source.sv ====
/*
 * Partner end: an APB-controlled trigger source that drives the hardware line
 * or the link trigger with programmed pulses, respecting exposure status.
 * Assumes an APB master on mclk; zero-wait answers, one access per transfer.
 */
`timescale 1ns/1ps
`default_nettype none
module trigger_source
    import exposure_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic reset_n, // Synchronous reset, active low
    exposure_link_if.host link, // Trigger lines toward the camera
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata_r, // APB read data
    output logic pready_r, // APB ready
    output logic pslverr_r // APB error on unmapped address
);
    typedef enum logic [1:0] {TS_IDLE, TS_HOLD, TS_PULSE, TS_FINISH} src_state_e;

    src_state_e state_r;
    logic [1:0] ctrl_r;
    logic [31:0] width_r;
    logic [31:0] cnt_r;
    logic pending_r;
    logic line_r;
    logic link_r;
    logic wr_go;
    logic access;
    logic mapped;

    assign access = psel && penable && pready_r;
    assign wr_go = access && pwrite && paddr == REG_GO;
    assign mapped = paddr == REG_CTRL || paddr == REG_WIDTH || paddr == REG_GO ||
                    paddr == REG_STATUS;

    // Ready rises in the access phase; read data sampled in setup
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= psel && !penable;
            pslverr_r <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    REG_CTRL: prdata_r <= {30'h0, ctrl_r};
                    REG_WIDTH: prdata_r <= width_r;
                    REG_STATUS: prdata_r <= {28'h0, link.readout_busy,
                        link.exposure_active, pending_r, state_r != TS_IDLE};
                    default: prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration writes
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctrl_r <= CTRL_RESET;
            width_r <= WIDTH_RESET;
        end else if (access && pwrite) begin
            if (paddr == REG_CTRL) begin
                ctrl_r <= pwdata[1:0];
            end
            if (paddr == REG_WIDTH) begin
                width_r <= pwdata;
            end
        end
    end

    // Pulse sequencer; a start never lands on an active exposure
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_r <= TS_IDLE;
            pending_r <= 1'b0;
            cnt_r <= 32'h0000_0000;
            line_r <= 1'b0;
            link_r <= 1'b0;
        end else begin
            if (wr_go) begin
                pending_r <= 1'b1;
            end
            case (state_r)
                TS_IDLE: begin
                    line_r <= ~ctrl_r[CTRL_ACTIVE_HIGH];
                    link_r <= ~ctrl_r[CTRL_ACTIVE_HIGH];
                    if (pending_r) begin
                        state_r <= TS_HOLD;
                    end
                end
                TS_HOLD: begin
                    if (!link.exposure_active) begin
                        pending_r <= wr_go;
                        cnt_r <= 32'h0000_0000;
                        if (ctrl_r[CTRL_USE_LINK]) begin
                            link_r <= ctrl_r[CTRL_ACTIVE_HIGH];
                        end else begin
                            line_r <= ctrl_r[CTRL_ACTIVE_HIGH];
                        end
                        state_r <= TS_PULSE;
                    end
                end
                TS_PULSE: begin
                    cnt_r <= cnt_r + 32'h0000_0001;
                    if (cnt_r + 32'h0000_0001 >= width_r && !link.readout_busy) begin
                        line_r <= ~ctrl_r[CTRL_ACTIVE_HIGH];
                        link_r <= ~ctrl_r[CTRL_ACTIVE_HIGH];
                        state_r <= TS_FINISH;
                    end
                end
                TS_FINISH: state_r <= TS_IDLE;
                default: state_r <= TS_IDLE;
            endcase
        end
    end

    assign link.hardware_trigger_input = line_r;
    assign link.link_trigger_input = link_r;
endmodule // trigger_source
`default_nettype wire

// ==== verif/exposure_trigger_control_assertions.sv ====
/*
 * Checker for the exposure link and the controller's status outputs.
 * Assumes it is instantiated in the bench beside the link interface, on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module exposure_trigger_control_assertions
    import exposure_pkg::*;
#(
    parameter int LINES = 16, // Sensor lines per frame
    parameter int LINE_CYCLES = 64 // Clocks per line
) (
    input wire logic mclk, // Clock
    input wire logic reset_n, // Reset, active low
    input wire logic hardware_trigger_input, // Trigger line
    input wire logic exposure_active, // Exposing
    input wire logic readout_busy, // Reading out
    input wire logic trigger_enable, // Triggered mode
    input wire logic [2:0] source_sel, // Start source
    input wire logic edge_rising, // Edge select
    input wire logic width_mode, // Width exposure
    input wire logic waiting_r, // Waiting state
    input wire logic frame_start_r, // Start pulse
    input wire logic line_strobe_r // Line pulse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Readout length counter; cleared outside a readout so overlaps cannot pile up
    logic [15:0] rd_cnt_r;
    always_ff @(posedge mclk) begin
        if (!reset_n || !readout_busy) begin
            rd_cnt_r <= 16'h0000;
        end else begin
            rd_cnt_r <= rd_cnt_r + 16'h0001;
        end
    end

    // Selected edge on the line while waiting
    sequence line_edge_s;
        trigger_enable && source_sel == SRC_LINE && waiting_r
            && (edge_rising ? $rose(hardware_trigger_input) : $fell(hardware_trigger_input));
    endsequence
    // Readout opens with its first line
    sequence rd_start_s;
        $rose(readout_busy) && line_strobe_r;
    endsequence

    start_on_edge_a: assert property (line_edge_s |->
        ##[1:2] exposure_active)
        else $error("edge did not start exposure");
    start_pulse_a: assert property ($rose(exposure_active) |->
        frame_start_r ##1 !frame_start_r)
        else $error("exposure rise without one start pulse");
    busy_no_wait_a: assert property (exposure_active |-> !waiting_r)
        else $error("waiting during exposure");
    rewait_a: assert property ($fell(exposure_active) |-> ##[0:1] waiting_r)
        else $error("no return to waiting");
    rise_width_a: assert property (trigger_enable && source_sel == SRC_LINE && width_mode
        && edge_rising && exposure_active && !readout_busy && $fell(hardware_trigger_input)
        |-> ##[1:2] !exposure_active)
        else $error("rising width exposure not ended");
    fall_width_a: assert property (trigger_enable && source_sel == SRC_LINE && width_mode
        && !edge_rising && exposure_active && !readout_busy && $rose(hardware_trigger_input)
        |-> ##[1:2] !exposure_active)
        else $error("falling width exposure not ended");
    delay_no_wait_a: assert property (trigger_enable && source_sel == SRC_TIMER && waiting_r
        && edge_rising && $rose(hardware_trigger_input) |=> !waiting_r)
        else $error("waiting during delay");
    readout_start_a: assert property ($fell(exposure_active) |-> rd_start_s)
        else $error("readout did not follow exposure");
    readout_len_a: assert property ($fell(readout_busy) |->
        rd_cnt_r == 16'(LINES * LINE_CYCLES))
        else $error("readout length wrong");
endmodule // exposure_trigger_control_assertions
`default_nettype wire

// ==== verif/exposure_trigger_control_tb_top.sv ====
/*
 * Bench: controller and APB trigger source joined by the link interface.
 * Assumes the core files are compiled first; times are 250 cycles per us.
 */
`timescale 1ns/1ps
`default_nettype none
module exposure_trigger_control_tb_top
    import exposure_pkg::*;
;
    localparam int LINES = 16;
    localparam int LC = 64;
    logic mclk, reset_n, psel, penable, pwrite, en, rise, wm, sw, lvl, err, ovl, tmr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata_r, rd;
    logic pready_r, pslverr_r, waiting_r, timer_r, frame_start_r, line_strobe_r;
    logic [2:0] src;
    logic [TIME_W-1:0] t_us, dly_us, dur_us, per_us;
    logic [15:0] line_index_r;
    int n_fail = 0;
    int compares = 0;
    int starts = 0;
    int n, k, m, s0;
    exposure_link_if lnk();

    exposure_trigger_control #(.LINES(LINES), .LINE_CYCLES(LC)) i_exposure_trigger_control (
        .mclk(mclk), .reset_n(reset_n), .link(lnk), .trigger_enable(en), .source_sel(src),
        .edge_rising(rise), .width_mode(wm), .exposure_time_us(t_us), .delay_us(dly_us),
        .timer_duration_us(dur_us), .frame_period_us(per_us), .software_trigger(sw),
        .software_level_output(lvl), .waiting_r(waiting_r), .delay_timer_output_r(timer_r),
        .frame_start_r(frame_start_r), .line_strobe_r(line_strobe_r),
        .line_index_r(line_index_r));
    trigger_source i_trigger_source (.mclk(mclk), .reset_n(reset_n), .link(lnk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r));
    exposure_trigger_control_assertions #(.LINES(LINES), .LINE_CYCLES(LC)) chk_link (
        .mclk(mclk), .reset_n(reset_n), .hardware_trigger_input(lnk.hardware_trigger_input),
        .exposure_active(lnk.exposure_active), .readout_busy(lnk.readout_busy),
        .trigger_enable(en), .source_sel(src), .edge_rising(rise), .width_mode(wm),
        .waiting_r(waiting_r), .frame_start_r(frame_start_r), .line_strobe_r(line_strobe_r));

    // 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Start pulses seen, to prove ignored triggers
    always @(posedge mclk) begin
        if (frame_start_r === 1'b1) begin
            starts <= starts + 1;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Cycle counts carry microsecond quantisation, hence a tolerance
    task automatic near(input string nm, input int e, input int g, input int tol);
        compares++;
        if (g < e - tol || g > e + tol) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // One APB transfer; waits for pready however long the slave takes
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready_r !== 1'b1);
        rd = prdata_r;
        err = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input logic e, input logic [2:0] s, input logic r, input logic w,
        input int t);
        @(posedge mclk);
        en <= e;
        src <= s;
        rise <= r;
        wm <= w;
        t_us <= TIME_W'(t);
    endtask

    // Waits for a start (k cycles), then counts exposure cycles
    task automatic xlen(output int len);
        k = 0;
        while (frame_start_r !== 1'b1 && k < 30000) begin
            @(posedge mclk);
            k++;
        end
        ovl = lnk.readout_busy;
        tmr = timer_r;
        len = 0;
        while (lnk.exposure_active === 1'b1 && len < 30000) begin
            @(posedge mclk);
            len++;
        end
    endtask

    task automatic idle;
        do @(posedge mclk); while (lnk.readout_busy !== 1'b0 || lnk.exposure_active !== 1'b0);
    endtask

    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard, well past the roughly 31000 cycles the tests need
    initial begin
        repeat (90000) @(posedge mclk);
        n_fail++;
        test_done();
    end

    initial begin
        {reset_n, psel, penable, pwrite, sw, lvl, rise, wm} = 8'h00;
        {paddr, pwdata} = 40'h0;
        en = 1'b1;
        src = SRC_SOFTWARE;
        t_us = 26'd12;
        dly_us = 26'd4;
        dur_us = 26'd12;
        per_us = 26'd20;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        // Reset state, host registers, unmapped address
        chk("waiting", 32'h1, {31'h0, waiting_r});
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", 32'h2, rd);
        apb(1'b0, REG_WIDTH, 32'h0);
        chk("width", WIDTH_RESET, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        // Line, rising width; second pulse queued lands during readout
        cfg(1'b1, SRC_LINE, 1'b1, 1'b1, 12);
        apb(1'b1, REG_WIDTH, 32'd400);
        apb(1'b1, REG_GO, 32'h0);
        apb(1'b1, REG_GO, 32'h0);
        xlen(n);
        near("rise width", 400, n, 2);
        xlen(n);
        chk("overlap", 32'h1, {31'h0, ovl});
        idle();
        chk("last line", 32'(LINES - 1), {16'h0, line_index_r});
        // Line, falling width with an active-low line
        cfg(1'b1, SRC_SOFTWARE, 1'b0, 1'b1, 12);
        apb(1'b1, REG_CTRL, 32'h0);
        cfg(1'b1, SRC_LINE, 1'b0, 1'b1, 12);
        apb(1'b1, REG_GO, 32'h0);
        xlen(n);
        near("fall width", 400, n, 2);
        idle();
        // Link, timed, below the minimum so it clamps to 12 us
        cfg(1'b1, SRC_SOFTWARE, 1'b1, 1'b0, 5);
        apb(1'b1, REG_CTRL, 32'h3);
        cfg(1'b1, SRC_LINK, 1'b1, 1'b0, 5);
        apb(1'b1, REG_WIDTH, 32'd50);
        apb(1'b1, REG_GO, 32'h0);
        xlen(n);
        near("timed min", 3000, n, 250);
        idle();
        // Software start in width mode; a second command mid-exposure is dropped
        cfg(1'b1, SRC_SOFTWARE, 1'b1, 1'b1, 12);
        s0 = starts;
        @(posedge mclk);
        sw <= 1'b1;
        @(posedge mclk);
        sw <= 1'b0;
        fork
            begin
                repeat (200) @(posedge mclk);
                sw <= 1'b1;
                @(posedge mclk);
                sw <= 1'b0;
            end
        join_none
        xlen(n);
        near("sw time", 3000, n, 250);
        idle();
        chk("starts", 32'h1, 32'(starts - s0));
        // Software level in width mode
        cfg(1'b1, SRC_LEVEL, 1'b1, 1'b1, 12);
        @(posedge mclk);
        lvl <= 1'b1;
        fork
            begin
                repeat (300) @(posedge mclk);
                lvl <= 1'b0;
            end
        join_none
        xlen(n);
        near("level width", 300, n, 2);
        idle();
        // Delay timer from the line: 4 us delay, 12 us duration
        cfg(1'b1, SRC_SOFTWARE, 1'b1, 1'b1, 12);
        apb(1'b1, REG_CTRL, 32'h2);
        cfg(1'b1, SRC_TIMER, 1'b1, 1'b1, 12);
        apb(1'b1, REG_GO, 32'h0);
        xlen(n);
        near("delay", 1000, k, 260);
        near("timer len", 3000, n, 250);
        chk("timer out", 32'h1, {31'h0, tmr});
        idle();
        // Free run at a 20 us period
        cfg(1'b0, SRC_LINE, 1'b1, 1'b0, 12);
        xlen(m);
        xlen(n);
        near("period", 5000, m + k, 300);
        test_done();
    end
endmodule // exposure_trigger_control_tb_top
`default_nettype wire
